// >>> verilog/bma_pkg.sv
// Constants, register offsets and enumerations for the coprocessor
// memory-access block. Shared by the design and by the bench.
package bma_pkg;

  // Register offsets on the byte-wide register port
  localparam logic [15:0] BMA_OFS_RV_LO = 16'h2203;
  localparam logic [15:0] BMA_OFS_RV_HI = 16'h2204;
  localparam logic [15:0] BMA_OFS_NV_LO = 16'h2205;
  localparam logic [15:0] BMA_OFS_NV_HI = 16'h2206;
  localparam logic [15:0] BMA_OFS_IV_LO = 16'h2207;
  localparam logic [15:0] BMA_OFS_IV_HI = 16'h2208;
  localparam logic [15:0] BMA_OFS_CONV_CTRL = 16'h2231;
  localparam logic [15:0] BMA_OFS_BM_CFG = 16'h223F;
  localparam logic [15:0] BMA_OFS_STATUS = 16'h2310;

  // Field layouts
  localparam int BMA_SIZE_LSB = 2;
  localparam int BMA_SIZE_MSB = 4;
  localparam int BMA_SEL_BIT = 7;
  localparam logic [2:0] BMA_SIZE_MAX = 3'h5;

  // Reset values
  localparam logic [7:0] BMA_RST_BYTE = 8'h00;
  localparam logic [15:0] BMA_RST_VEC = 16'h0000;

  // Memory map of the coprocessor core
  localparam logic [7:0] BMA_BANK_BWR_LO = 8'h40;
  localparam logic [7:0] BMA_BANK_BWR_HI = 8'h4F;
  localparam logic [7:0] BMA_BANK_BM_LO = 8'h60;
  localparam logic [7:0] BMA_BANK_BM_HI = 8'h6F;
  localparam logic [7:0] BMA_BANK_HROM_LO = 8'hC0;
  localparam logic [1:0] BMA_LOROM_QTR_MASK = 2'h2;
  localparam logic [15:0] BMA_IRAM_LO = 16'h3000;
  localparam logic [15:0] BMA_IRAM_HI = 16'h37FF;
  localparam logic [23:0] BMA_BWR_BASE = 24'h400000;

  // Pixel geometry
  localparam logic [8:0] BMA_CHAR_DOTS = 9'h008;
  localparam logic [7:0] BMA_PIX4_MASK = 8'h03;
  localparam logic [7:0] BMA_PIX16_MASK = 8'h0F;

  // Memory targeted by an access
  typedef enum logic [2:0] {
    BMA_RGN_NONE = 3'h0,
    BMA_RGN_ROM = 3'h1,
    BMA_RGN_BWR = 3'h2,
    BMA_RGN_IRAM = 3'h3,
    BMA_RGN_BITMAP = 3'h4
  } bma_rgn_t;

  // Instruction classes reported by the core's decoder
  typedef enum logic [2:0] {
    BMA_IC_OTHER = 3'h0,
    BMA_IC_RETURN = 3'h1,
    BMA_IC_JUMP = 3'h2,
    BMA_IC_JUMP_IDX = 3'h3,
    BMA_IC_CALL = 3'h4,
    BMA_IC_BR_COND = 3'h5,
    BMA_IC_BR_SHORT = 3'h6,
    BMA_IC_BR_LONG = 3'h7
  } bma_iclass_t;

  // Vector being fetched
  typedef enum logic [1:0] {
    BMA_VK_RESET = 2'h0,
    BMA_VK_NMI = 2'h1,
    BMA_VK_IRQ = 2'h2,
    BMA_VK_OTHER = 2'h3
  } bma_vkind_t;

  // Bitmap window sequencer, one-hot
  typedef enum logic [4:0] {
    BMA_BM_IDLE = 5'b00001,
    BMA_BM_RD = 5'b00010,
    BMA_BM_CAP = 5'b00100,
    BMA_BM_WR = 5'b01000,
    BMA_BM_DONE = 5'b10000
  } bma_bm_state_t;

endpackage

// >>> verilog/bma_bitmap_memory_access.sv
// Memory-access logic beside the coprocessor core: vector substitution,
// wait-cycle insertion and the unpacked bitmap window on backup RAM.
// Assumes the core holds its access request until o_cpu_wait is low and
// that backup RAM returns read data one cycle after its read strobe.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps

module bma_bitmap_memory_access
  import bma_pkg::*;
#(
  parameter int BWR_AW = 18
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [15:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Coprocessor core data access
  input wire logic [23:0] i_cpu_addr,
  input wire logic i_cpu_rd,
  input wire logic i_cpu_wr,
  input wire logic [7:0] i_cpu_wdata,
  output logic o_cpu_wait,
  output logic [7:0] o_cpu_rdata,
  // Coprocessor core instruction events
  input wire logic i_instr_evt,
  input wire bma_iclass_t i_instr_class,
  input wire logic i_branch_taken,
  input wire logic [23:0] i_branch_target,
  // Vector fetch
  input wire logic i_vec_fetch,
  input wire bma_vkind_t i_vec_kind,
  output logic o_vec_valid,
  output logic o_vec_from_reg,
  output logic [15:0] o_vec_data,
  // Activity of the other bus masters
  input wire bma_rgn_t i_main_rgn,
  input wire bma_rgn_t i_main_dma_rgn,
  input wire logic i_dma_rom_src,
  input wire logic i_bwr_wbuf_full,
  // Backup RAM port of the bitmap window
  output logic [23:0] o_bwr_addr,
  output logic o_bwr_rd,
  output logic o_bwr_wr,
  output logic [7:0] o_bwr_wdata,
  input wire logic [7:0] i_bwr_rdata,
  // Virtual VRAM pixel address helper
  input wire logic [23:0] i_pix_base,
  input wire logic [11:0] i_pix_row,
  input wire logic [7:0] i_pix_col,
  output logic [23:0] o_pix_addr,
  output logic [8:0] o_hdots
);

  // Which memory an address falls into
  function automatic bma_rgn_t rgn_of(input logic [23:0] a);
    logic [7:0] bk;
    bk = a[23:16];
    if (bk >= BMA_BANK_BM_LO && bk <= BMA_BANK_BM_HI) begin
      return BMA_RGN_BITMAP;
    end else if (bk >= BMA_BANK_BWR_LO && bk <= BMA_BANK_BWR_HI) begin
      return BMA_RGN_BWR;
    end else if (bk >= BMA_BANK_HROM_LO) begin
      return BMA_RGN_ROM;
    end else if (bk[6] == 1'b0 && a[15]) begin
      return BMA_RGN_ROM;
    end else if (bk[6] == 1'b0 && a[15:0] >= BMA_IRAM_LO &&
                 a[15:0] <= BMA_IRAM_HI) begin
      return BMA_RGN_IRAM;
    end else begin
      return BMA_RGN_NONE;
    end
  endfunction

  // Horizontal size in dots; unused codes clamp to the widest
  function automatic logic [8:0] hdots(input logic [2:0] sz);
    logic [2:0] s;
    s = (sz > BMA_SIZE_MAX) ? BMA_SIZE_MAX : sz;
    return BMA_CHAR_DOTS << s;
  endfunction

  // Pixel extract, right-aligned, upper bits zero
  function automatic logic [7:0] pix_get(input logic [7:0] b,
                                         input logic [1:0] sel,
                                         input logic four);
    if (four) begin
      return (b >> {sel, 1'b0}) & BMA_PIX4_MASK;
    end else begin
      return (b >> {sel[0], 2'b00}) & BMA_PIX16_MASK;
    end
  endfunction

  // Pixel insert, neighbours kept
  function automatic logic [7:0] pix_put(input logic [7:0] b,
                                         input logic [1:0] sel,
                                         input logic four,
                                         input logic [7:0] v);
    logic [7:0] m;
    logic [7:0] d;
    if (four) begin
      m = BMA_PIX4_MASK << {sel, 1'b0};
      d = (v & BMA_PIX4_MASK) << {sel, 1'b0};
    end else begin
      m = BMA_PIX16_MASK << {sel[0], 2'b00};
      d = (v & BMA_PIX16_MASK) << {sel[0], 2'b00};
    end
    return (b & ~m) | (d & m);
  endfunction

  logic [15:0] rv_ff;
  logic [15:0] nv_ff;
  logic [15:0] iv_ff;
  logic [2:0] hsize_ff;
  logic color4_ff;
  logic pend_ff;
  logic rdwait_done_ff;
  bma_bm_state_t bm_ff;
  logic mode4_ff;
  logic [1:0] sel_ff;
  logic is_wr_ff;
  logic [7:0] wval_ff;
  logic req;
  bma_rgn_t cpu_rgn;
  bma_rgn_t cmp_rgn;
  logic conflict;
  logic rd_needs_wait;
  logic wbuf_blk;
  logic gen_done;
  logic bm_hit;
  logic hold;
  logic [19:0] win_off;
  logic [19:0] pk_off;
  logic [19:0] pk_mask;
  logic [7:0] status;

  // Access classification
  assign req = i_cpu_rd | i_cpu_wr;
  assign cpu_rgn = rgn_of(i_cpu_addr);
  assign bm_hit = req && (cpu_rgn == BMA_RGN_BITMAP);
  // The window shares the physical backup RAM with the packed area
  assign cmp_rgn = (cpu_rgn == BMA_RGN_BITMAP) ? BMA_RGN_BWR : cpu_rgn;
  assign conflict = req && (cmp_rgn != BMA_RGN_NONE) &&
                    (cmp_rgn == i_main_rgn ||
                     cmp_rgn == i_main_dma_rgn);
  assign rd_needs_wait = i_cpu_rd && (cpu_rgn == BMA_RGN_ROM ||
                                      cpu_rgn == BMA_RGN_BWR);
  assign wbuf_blk = i_cpu_wr && (cpu_rgn == BMA_RGN_BWR) &&
                    i_bwr_wbuf_full;
  assign gen_done = !conflict && !wbuf_blk &&
                    (!rd_needs_wait || rdwait_done_ff);
  // Stalls that hold every access, whatever its target
  assign hold = pend_ff | i_dma_rom_src;

  // Wait to the core; bitmap accesses finish only in the last state
  always_comb begin
    if (hold) begin
      o_cpu_wait = 1'b1;
    end else if (bm_hit) begin
      o_cpu_wait = (bm_ff != BMA_BM_DONE);
    end else begin
      o_cpu_wait = req && !gen_done;
    end
  end

  // Unpacked window offset to packed byte; the whole RAM is covered
  // and addresses past its size wrap onto it
  assign win_off = i_cpu_addr[19:0];
  assign pk_off = color4_ff ? {2'b00, win_off[19:2]} :
                              {1'b0, win_off[19:1]};
  assign pk_mask = 20'((21'h000001 << BWR_AW) - 21'h000001);

  // Bitmap window sequencer strobes
  assign o_bwr_rd = (bm_ff == BMA_BM_RD);
  assign o_bwr_wr = (bm_ff == BMA_BM_WR) && !i_bwr_wbuf_full;

  // Vector registers, written by the main CPU
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rv_ff <= BMA_RST_VEC;
      nv_ff <= BMA_RST_VEC;
      iv_ff <= BMA_RST_VEC;
    end else if (i_reg_wr) begin
      if (i_reg_addr == BMA_OFS_RV_LO) begin
        rv_ff[7:0] <= i_reg_wdata;
      end else if (i_reg_addr == BMA_OFS_RV_HI) begin
        rv_ff[15:8] <= i_reg_wdata;
      end else if (i_reg_addr == BMA_OFS_NV_LO) begin
        nv_ff[7:0] <= i_reg_wdata;
      end else if (i_reg_addr == BMA_OFS_NV_HI) begin
        nv_ff[15:8] <= i_reg_wdata;
      end else if (i_reg_addr == BMA_OFS_IV_LO) begin
        iv_ff[7:0] <= i_reg_wdata;
      end else if (i_reg_addr == BMA_OFS_IV_HI) begin
        iv_ff[15:8] <= i_reg_wdata;
      end
    end
  end

  // Bitmap geometry and color mode
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      hsize_ff <= BMA_RST_BYTE[2:0];
      color4_ff <= 1'b0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == BMA_OFS_CONV_CTRL) begin
        hsize_ff <= i_reg_wdata[BMA_SIZE_MSB:BMA_SIZE_LSB];
      end else if (i_reg_addr == BMA_OFS_BM_CFG) begin
        color4_ff <= i_reg_wdata[BMA_SEL_BIT];
      end
    end
  end

  // Live status for software
  assign status = {3'h0, conflict, !(bm_ff == BMA_BM_IDLE), i_dma_rom_src,
                   pend_ff, o_cpu_wait};

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || !i_reg_rd) begin
      o_reg_rdata <= BMA_RST_BYTE;
    end else if (i_reg_addr == BMA_OFS_RV_LO) begin
      o_reg_rdata <= rv_ff[7:0];
    end else if (i_reg_addr == BMA_OFS_RV_HI) begin
      o_reg_rdata <= rv_ff[15:8];
    end else if (i_reg_addr == BMA_OFS_NV_LO) begin
      o_reg_rdata <= nv_ff[7:0];
    end else if (i_reg_addr == BMA_OFS_NV_HI) begin
      o_reg_rdata <= nv_ff[15:8];
    end else if (i_reg_addr == BMA_OFS_IV_LO) begin
      o_reg_rdata <= iv_ff[7:0];
    end else if (i_reg_addr == BMA_OFS_IV_HI) begin
      o_reg_rdata <= iv_ff[15:8];
    end else if (i_reg_addr == BMA_OFS_CONV_CTRL) begin
      o_reg_rdata <= {3'h0, hsize_ff, 2'h0};
    end else if (i_reg_addr == BMA_OFS_BM_CFG) begin
      o_reg_rdata <= {color4_ff, 7'h00};
    end else if (i_reg_addr == BMA_OFS_STATUS) begin
      o_reg_rdata <= status;
    end else begin
      o_reg_rdata <= BMA_RST_BYTE;
    end
  end

  // One stall cycle after a costly instruction or odd branch target
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pend_ff <= 1'b0;
    end else if (i_instr_evt) begin
      case (i_instr_class)
        BMA_IC_RETURN, BMA_IC_JUMP, BMA_IC_JUMP_IDX, BMA_IC_CALL: begin
          pend_ff <= 1'b1;
        end
        BMA_IC_BR_COND, BMA_IC_BR_SHORT, BMA_IC_BR_LONG: begin
          pend_ff <= i_branch_taken && i_branch_target[0];
        end
        default: begin
          pend_ff <= 1'b0;
        end
      endcase
    end else begin
      pend_ff <= 1'b0;
    end
  end

  // Marks the first cycle of a slow read as spent
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || !req || !o_cpu_wait) begin
      rdwait_done_ff <= 1'b0;
    end else if (rd_needs_wait) begin
      rdwait_done_ff <= 1'b1;
    end
  end

  // Vector substitution, answered one cycle after the fetch
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_vec_valid <= 1'b0;
      o_vec_from_reg <= 1'b0;
      o_vec_data <= BMA_RST_VEC;
    end else begin
      o_vec_valid <= i_vec_fetch;
      if (i_vec_fetch) begin
        case (i_vec_kind)
          BMA_VK_RESET: begin
            o_vec_from_reg <= 1'b1;
            o_vec_data <= rv_ff;
          end
          BMA_VK_NMI: begin
            o_vec_from_reg <= 1'b1;
            o_vec_data <= nv_ff;
          end
          BMA_VK_IRQ: begin
            o_vec_from_reg <= 1'b1;
            o_vec_data <= iv_ff;
          end
          default: begin
            // Program ROM supplies every other vector
            o_vec_from_reg <= 1'b0;
            o_vec_data <= BMA_RST_VEC;
          end
        endcase
      end
    end
  end

  // Bitmap window sequencer. Only the 4- and 16-color forms unpack;
  // 256-color bitmaps live one per byte in the packed area itself.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      bm_ff <= BMA_BM_IDLE;
      mode4_ff <= 1'b0;
      sel_ff <= 2'h0;
      is_wr_ff <= 1'b0;
      wval_ff <= BMA_RST_BYTE;
      o_bwr_addr <= BMA_BWR_BASE;
      o_bwr_wdata <= BMA_RST_BYTE;
      o_cpu_rdata <= BMA_RST_BYTE;
    end else begin
      case (bm_ff)
        BMA_BM_IDLE: begin
          if (bm_hit && !conflict && !hold) begin
            mode4_ff <= color4_ff;
            sel_ff <= win_off[1:0];
            is_wr_ff <= i_cpu_wr;
            wval_ff <= i_cpu_wdata;
            o_bwr_addr <= BMA_BWR_BASE | {4'h0, pk_off & pk_mask};
            bm_ff <= BMA_BM_RD;
          end
        end
        BMA_BM_RD: begin
          bm_ff <= BMA_BM_CAP;
        end
        BMA_BM_CAP: begin
          if (is_wr_ff) begin
            o_bwr_wdata <= pix_put(i_bwr_rdata, sel_ff, mode4_ff,
                                   wval_ff);
            bm_ff <= BMA_BM_WR;
          end else begin
            o_cpu_rdata <= pix_get(i_bwr_rdata, sel_ff,
                                   mode4_ff);
            bm_ff <= BMA_BM_DONE;
          end
        end
        BMA_BM_WR: begin
          if (!i_bwr_wbuf_full) begin
            bm_ff <= BMA_BM_DONE;
          end
        end
        BMA_BM_DONE: begin
          // Stay until the core actually sees the access finish
          if (!hold) begin
            bm_ff <= BMA_BM_IDLE;
          end
        end
        default: begin
          bm_ff <= BMA_BM_IDLE;
        end
      endcase
    end
  end

  // Pixel address; vertical size is software's business
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_pix_addr <= BMA_BWR_BASE;
      o_hdots <= BMA_CHAR_DOTS;
    end else begin
      o_hdots <= hdots(hsize_ff);
      // Widen before the product so tall rows do not wrap at 12 bits
      o_pix_addr <= i_pix_base + 24'(i_pix_row) * 24'(hdots(hsize_ff)) +
                    {16'h0000, i_pix_col};
    end
  end

endmodule // bma_bitmap_memory_access

// >>> sim/bma_props.sv
// Checker for the memory-access block: stalls, vectors, window timing.
// Sees only the top module's ports; bound to the design below.
`timescale 1ns/10ps

module bma_props
  import bma_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Core side
  input wire logic [23:0] i_cpu_addr,
  input wire logic i_cpu_rd,
  input wire logic i_cpu_wr,
  input wire logic o_cpu_wait,
  input wire logic i_instr_evt,
  input wire bma_iclass_t i_instr_class,
  input wire logic i_branch_taken,
  input wire logic [23:0] i_branch_target,
  input wire logic i_vec_fetch,
  input wire bma_vkind_t i_vec_kind,
  input wire logic o_vec_valid,
  input wire logic o_vec_from_reg,
  // Other masters and backup RAM
  input wire bma_rgn_t i_main_rgn,
  input wire logic i_dma_rom_src,
  input wire logic i_bwr_wbuf_full,
  input wire logic o_bwr_rd,
  input wire logic o_bwr_wr,
  input wire logic [8:0] o_hdots
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  logic req;
  // Any core request
  assign req = i_cpu_rd | i_cpu_wr;

  a_vec_answer: assert property (
    i_vec_fetch |=> o_vec_valid) else $error("vector answer missing");
  a_vec_source: assert property (
    i_vec_fetch |=> o_vec_from_reg == ($past(i_vec_kind) != BMA_VK_OTHER))
    else $error("vector source wrong");
  a_cost_wait: assert property (
    i_instr_evt && i_instr_class inside {[BMA_IC_RETURN:BMA_IC_CALL]}
    ##1 req |-> o_cpu_wait) else $error("no wait after costly op");
  a_odd_branch: assert property (
    i_instr_evt && i_instr_class >= BMA_IC_BR_COND && i_branch_taken
    && i_branch_target[0] ##1 req |-> o_cpu_wait)
    else $error("no wait after odd branch");
  a_slow_read: assert property (
    i_cpu_rd && !$past(i_cpu_rd) && i_cpu_addr[23:22] == 2'h3
    |-> o_cpu_wait) else $error("rom read not stretched");
  a_mem_clash: assert property (
    req && i_cpu_addr[23:11] == 13'h0006 && i_main_rgn == BMA_RGN_IRAM
    |-> o_cpu_wait) else $error("internal ram clash not held");
  a_dma_stall: assert property (
    i_dma_rom_src && req |-> o_cpu_wait) else $error("dma stall missing");
  a_wbuf_hold: assert property (
    i_cpu_wr && i_cpu_addr[23:20] inside {4'h4, 4'h6} && i_bwr_wbuf_full
    |-> o_cpu_wait && !o_bwr_wr) else $error("write ran into full buffer");
  a_win_read: assert property (
    $rose(i_cpu_rd) && i_cpu_addr[23:20] == 4'h6 && !i_dma_rom_src
    && i_main_rgn == BMA_RGN_NONE |-> o_cpu_wait [*3] ##1 !o_cpu_wait)
    else $error("window read length wrong");
  a_bwr_fetch: assert property (
    o_bwr_rd |-> o_cpu_wait ##1 o_cpu_wait) else $error("early finish");
  a_hdots_code: assert property (
    o_hdots inside {9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100})
    else $error("width out of range");
endmodule // bma_props

bind bma_bitmap_memory_access bma_props bma_props_inst (.*);

// >>> sim/bma_bwr_model.sv
// Backup RAM behind the window port: 256 bytes on the low address bits.
// Read data stand one cycle after the strobe, else a changing pattern.
`timescale 1ns/10ps

module bma_bwr_model (
  // Clock
  input wire logic i_sys_clk,
  // Window port
  input wire logic [23:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [256];
  // Inverting between reads so stale data never look valid
  always @(posedge i_sys_clk) begin
    if (i_wr) begin
      mem[i_addr[7:0]] <= i_wdata;
    end
    o_rdata <= i_rd ? mem[i_addr[7:0]] : ~o_rdata;
  end
endmodule // bma_bwr_model

// >>> sim/tb_top.sv
// Self-checking bench for the memory-access block and its window.
// Inputs change at the rising edge; backup RAM is a behavioural model.
`timescale 1ns/10ps

module tb_top;
  import bma_pkg::*;
  logic i_sys_clk = 0, i_sys_rst = 1;
  logic [15:0] i_reg_addr = 0;
  logic [7:0] i_reg_wdata = 0, i_cpu_wdata = 0, i_pix_col = 0;
  logic i_reg_wr = 0, i_reg_rd = 0, i_cpu_rd = 0, i_cpu_wr = 0;
  logic i_instr_evt = 0, i_branch_taken = 0, i_vec_fetch = 0;
  logic i_dma_rom_src = 0, i_bwr_wbuf_full = 0;
  logic [23:0] i_cpu_addr = 0, i_branch_target = 0, i_pix_base = 0;
  logic [11:0] i_pix_row = 0;
  bma_iclass_t i_instr_class = BMA_IC_OTHER;
  bma_vkind_t i_vec_kind = BMA_VK_OTHER;
  bma_rgn_t i_main_rgn = BMA_RGN_NONE, i_main_dma_rgn = BMA_RGN_NONE;
  logic [7:0] o_reg_rdata, o_cpu_rdata, o_bwr_wdata, i_bwr_rdata, rd8;
  logic [23:0] o_bwr_addr, o_pix_addr, seen;
  logic [15:0] o_vec_data;
  logic [8:0] o_hdots;
  logic o_cpu_wait, o_vec_valid, o_vec_from_reg, o_bwr_rd, o_bwr_wr;
  int error_cnt = 0, cmp_count = 0, n;

  bma_bitmap_memory_access bma_bitmap_memory_access_inst (.*);
  bma_bwr_model bma_bwr_model_inst (.i_sys_clk, .i_addr(o_bwr_addr),
    .i_rd(o_bwr_rd), .i_wr(o_bwr_wr), .i_wdata(o_bwr_wdata),
    .o_rdata(i_bwr_rdata));

  // 25 MHz clock
  always #20 i_sys_clk = ~i_sys_clk;

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1;
    @(posedge i_sys_clk);
    i_reg_wr <= 0;
  endtask

  task automatic reg_rd(input logic [15:0] a);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1;
    @(posedge i_sys_clk);
    i_reg_rd <= 0;
    #1 rd8 = o_reg_rdata;
  endtask

  task automatic start(input logic [23:0] a, input logic w,
                       input logic [7:0] d);
    @(posedge i_sys_clk);
    i_cpu_addr <= a;
    i_cpu_rd <= !w;
    i_cpu_wr <= w;
    i_cpu_wdata <= d;
  endtask

  // Waits out the stall under a bound, then drops the request
  task automatic fin;
    #1 n = 0;
    seen = 24'h0;
    while (o_cpu_wait !== 1'b0 && n < 20) begin
      @(posedge i_sys_clk);
      #1 n++;
      if (o_bwr_rd === 1'b1) seen = o_bwr_addr;
    end
    rd8 = o_cpu_rdata;
    @(posedge i_sys_clk);
    i_cpu_rd <= 0;
    i_cpu_wr <= 0;
  endtask

  task automatic cpu(input logic [23:0] a, input logic w,
                     input logic [7:0] d);
    start(a, w, d);
    fin();
  endtask

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    error_cnt++;
    results();
  end

  initial begin
    bma_bwr_model_inst.mem[8'h10] = 8'hA5;
    repeat (3) @(posedge i_sys_clk);
    i_sys_rst <= 0;
    #1 chk(o_hdots, 24'h8);
    chk(o_bwr_addr, BMA_BWR_BASE);
    for (int k = 0; k < 3; k++) begin
      reg_wr(BMA_OFS_RV_LO + 16'(2 * k), 8'h50 | 8'(k));
      reg_wr(BMA_OFS_RV_HI + 16'(2 * k), 8'hA0 | 8'(k));
    end
    reg_rd(BMA_OFS_NV_HI);
    chk(rd8, 8'hA1);
    reg_rd(16'h2300);
    chk(rd8, 8'h00);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_sys_clk);
      i_vec_fetch <= 1;
      i_vec_kind <= bma_vkind_t'(k);
      @(posedge i_sys_clk);
      i_vec_fetch <= 0;
      #1 chk(o_vec_valid, 1);
      chk(o_vec_from_reg, k < 3);
      chk(o_vec_data, k < 3 ? {8'hA0 | 8'(k), 8'h50 | 8'(k)} : 0);
    end
    // Codes 6 and 7 are unused and clamp to the widest size
    for (int s = 0; s < 8; s++) begin
      reg_wr(BMA_OFS_CONV_CTRL, 8'(s << BMA_SIZE_LSB));
      @(posedge i_sys_clk);
      #1 chk(o_hdots, 24'(8 << (s > 5 ? 5 : s)));
    end
    @(posedge i_sys_clk);
    i_pix_base <= 24'h012340;
    i_pix_row <= 12'h013;
    i_pix_col <= 8'h07;
    repeat (2) @(posedge i_sys_clk);
    #1 chk(o_pix_addr, 24'h013647);
    cpu(24'hC00000, 0, 0);
    chk(n, 1);
    cpu(24'h400010, 0, 0);
    chk(n, 1);
    cpu(24'h003000, 0, 0);
    chk(n, 0);
    for (int k = 0; k < 4; k++) begin
      start(k == 3 ? 24'h400020 : 24'h003000, k == 3, 8'h11);
      i_main_rgn <= k == 0 ? BMA_RGN_IRAM : BMA_RGN_NONE;
      i_main_dma_rgn <= k == 1 ? BMA_RGN_IRAM : BMA_RGN_NONE;
      i_dma_rom_src <= k == 2;
      i_bwr_wbuf_full <= k == 3;
      repeat (3) begin
        @(posedge i_sys_clk);
        #1 chk(o_cpu_wait, 1);
      end
      // Live status while the stall cause still stands
      reg_rd(BMA_OFS_STATUS);
      chk(rd8, k < 2 ? 8'h11 : k == 2 ? 8'h05 : 8'h01);
      @(posedge i_sys_clk);
      i_main_rgn <= BMA_RGN_NONE;
      i_main_dma_rgn <= BMA_RGN_NONE;
      i_dma_rom_src <= 0;
      i_bwr_wbuf_full <= 0;
      fin();
      chk(n < 3, 1);
    end
    start(24'h003000, 0, 0);
    for (int i = 0; i < 10; i++) begin
      @(posedge i_sys_clk);
      i_instr_evt <= 1;
      i_instr_class <= bma_iclass_t'(i < 8 ? i : i - 3);
      i_branch_taken <= i != 9;
      i_branch_target <= {23'h0, i != 8};
      @(posedge i_sys_clk);
      i_instr_evt <= 0;
      #1 chk(o_cpu_wait, i > 0 && i < 8);
    end
    fin();
    reg_wr(BMA_OFS_BM_CFG, 8'h00);
    cpu(24'h600020, 0, 0);
    chk(n, 3);
    chk(rd8, 8'h05);
    chk(seen, 24'h400010);
    cpu(24'h600021, 0, 0);
    chk(rd8, 8'h0A);
    cpu(24'h600021, 1, 8'h3C);
    chk(n, 4);
    chk(bma_bwr_model_inst.mem[8'h10], 8'hC5);
    reg_wr(BMA_OFS_BM_CFG, 8'h80);
    reg_rd(BMA_OFS_BM_CFG);
    chk(rd8, 8'h80);
    cpu(24'h600043, 0, 0);
    chk(rd8, 8'h03);
    cpu(24'h600041, 1, 8'hFE);
    chk(bma_bwr_model_inst.mem[8'h10], 8'hC9);
    cpu(24'h6FFFFF, 0, 0);
    chk(seen, 24'h43FFFF);
    reg_wr(BMA_OFS_BM_CFG, 8'h00);
    cpu(24'h67FFFF, 0, 0);
    chk(seen, 24'h43FFFF);
    cpu(24'h603FFF, 0, 0);
    chk(seen, 24'h401FFF);
    cpu(24'h60FFFF, 0, 0);
    chk(seen, 24'h407FFF);
    results();
  end
endmodule // tb_top
